// ---- hw/nvmsp_ctrl.sv ----
// Purpose: NVM controller for self-programming and EEPROM page programming
// Assumes: flash, EEPROM and CRC engine are outside; CPU strobes on CLK
// Notes: registers over AXI4-Lite, one write and one read in flight
//
// Overview of operation
// (RULE_01) Requester erases EEPROM locations before writing them from the buffer.
// (RULE_02) Requester loads the EEPROM buffer before any page erase or write.
// (RULE_03) EEPROM: fill, erase, write; or fill then atomic erase-and-write.
// (RULE_04) Power-on detector on while programming; brownout forced on in debug or chip erase. Code enables the detector in ST_PROG only, not in ST_EE.
// (RULE_05) Supply dropping to a watched level aborts programming at once.
// (RULE_06) Requester restarts programming after an abort once supply is good.
// (RULE_07) Range CRC always reads an even number of bytes.
// (RULE_08) Boot code may read and write flash, user row and EEPROM.
// (RULE_09) Application code only reads flash, rows and fuses; EEPROM read/write allowed.
// (RULE_10) Boot code may program any page, its own section included.
// (RULE_11) Application page operation halts CPU; boot section stays readable.
// (RULE_12) Boot page operation halts CPU; nothing readable.
// (RULE_13) User row operations behave like boot page operations.
// (RULE_14) Word in page taken from pointer bits one to word top bit.
// (RULE_15) Page number taken from pointer bits above the word field.
// (RULE_16) Pointer bit zero selects low or high byte of a read.
// (RULE_17) Target address latched at start; pointer free afterwards.
// (RULE_18) Action on execute bit, reads on load instr, writes on store instr.
// (RULE_19) CPU triggers need the unlock sequence; debug port requests do not.
// (RULE_20) Busy blocks writes to command, control, address and data registers.
// (RULE_21) Loaded EEPROM buffer bytes are marked; page ops touch only marked bytes.
// (RULE_22) Erasing the EEPROM buffer clears all marks.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module nvmsp_ctrl import nvmsp_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter logic [PGW-1:0] BOOT_PAGE = BOOT_PAGE_DEF
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // AXI4-Lite slave
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // CPU side
  input wire logic IN_BOOT,
  input wire logic PDI_REQ,
  input wire logic PDI_EN,
  input wire logic CCP_OPEN,
  input wire logic LOAD_INSTR,
  input wire logic STORE_INSTR,
  input wire logic [ZW-1:0] Z_PTR,
  input wire logic [15:0] STORE_DATA,
  output logic [7:0] RD_BYTE,
  output logic RD_VLD,
  output logic CPU_HALT,
  // Flash array
  output nvmsp_freq_t FL_REQ,
  output logic FL_START,
  output logic [15:0] FL_WDATA,
  output logic FL_ABORT,
  input wire logic FL_DONE,
  output logic [ZW-2:0] FL_RADDR,
  input wire logic [15:0] FL_RDATA,
  output logic BOOT_RD_EN,
  output logic APP_RD_EN,
  // EEPROM array
  output nvmsp_eereq_t EE_REQ,
  output logic EE_START,
  input wire logic EE_DONE,
  // CRC engine
  output logic [7:0] CRC_BYTE,
  output logic CRC_VLD,
  // Supply monitor
  input wire logic POT_LOW,
  input wire logic BOD_LOW,
  output logic POT_DET_EN,
  output logic BOD_FORCE
);
  nvmsp_state_t st_q, st_d;
  logic aw_have_q, w_have_q, chip_q, tgt_boot_q, tb_d;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, cur_w, wd, rd_val;
  logic [3:0] wstrb_q;
  logic [6:0] cmd_q;
  logic [ZW-1:0] addr_q, data_q, crc_ptr_q, crc_last_q;
  logic abort_q, deny_q, rd_pend_q, rd_sel_q, crc_pend_q, crc_sel_q;
  logic [ZW-1:0] crc_cnt_q;
  logic pot_low_s, bod_low_s;
  logic [EE_DEPTH-1:0] ee_tag;
  logic [8*EE_DEPTH-1:0] ee_data;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n,
                                      input logic [3:0] s);
    for (int i = 0; i < 4; i++) mrg[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
  endfunction

  function automatic logic [31:0] rmux(input logic [4:0] a);
    case (a)
      OFS_CMD: rmux = {25'h0, cmd_q};
      OFS_ADDR: rmux = {15'h0, addr_q};
      OFS_DATA: rmux = {15'h0, data_q};
      OFS_STATUS: rmux = {29'h0, deny_q, abort_q, st_q != ST_IDLE};
      default: rmux = 32'h0;
    endcase
  endfunction

  // Supply pins are asynchronous
  nvmsp_sync #(.W(2)) u_sync (
    .clk(CLK), .rst_b(RST_B), .din({POT_LOW, BOD_LOW}), .dout({pot_low_s, bod_low_s})
  );

  // Decode
  wire busy = (st_q != ST_IDLE) | crc_pend_q;
  wire wr_go = aw_have_q & w_have_q & ~S_AXI_BVALID;
  wire [4:0] wofs = awaddr_q[4:0];
  wire wmap = (awaddr_q[ADDR_W-1:5] == '0) & (wofs[1:0] == 2'h0) & (wofs <= OFS_STATUS);
  wire wok = wr_go & wmap & ~(busy & (wofs != OFS_STATUS)); // [RULE_20]
  wire [4:0] rofs = S_AXI_ARADDR[4:0];
  wire rmap = (S_AXI_ARADDR[ADDR_W-1:5] == '0) & (rofs[1:0] == 2'h0) & (rofs <= OFS_STATUS);
  assign cur_w = rmux(wofs);
  assign wd = mrg(cur_w, wdata_q, wstrb_q);
  assign rd_val = rmux(rofs);

  // Pointer split
  wire [PGW-1:0] z_page = Z_PTR[PAGE_MSB:WORD_MSB+1]; // [RULE_15]
  wire [WORD_MSB-1:0] z_word = Z_PTR[WORD_MSB:1]; // [RULE_14]

  wire is_fpg = cmd_q inside {CMD_ER_FPG, CMD_WR_FPG, CMD_EW_FPG};
  wire is_boot = cmd_q inside {CMD_WR_BOOT_PG, CMD_EW_BOOT_PG, CMD_ER_USIG, CMD_WR_USIG};
  wire is_fw = is_fpg | is_boot |
               (cmd_q inside {CMD_ER_APP, CMD_ER_APP_PG, CMD_WR_APP_PG, CMD_EW_APP_PG});
  wire is_eepg = cmd_q inside {CMD_ER_EEPG, CMD_WR_EEPG, CMD_EW_EEPG};
  wire prot_ok = PDI_REQ | CCP_OPEN; // [RULE_19]
  wire priv_ok = PDI_REQ | IN_BOOT; // [RULE_08] [RULE_09]
  wire st_go = STORE_INSTR & ~busy; // [RULE_18]
  wire fl_go = st_go & is_fw & prot_ok & priv_ok; // [RULE_10]
  wire ee_go = st_go & is_eepg & prot_ok; // [RULE_03]
  wire deny = st_go & ((is_fw & ~(prot_ok & priv_ok)) | (is_eepg & ~prot_ok) |
              ((cmd_q == CMD_LD_FBUF) & ~priv_ok));
  wire fbuf_ld = st_go & (cmd_q == CMD_LD_FBUF) & priv_ok;
  wire eebuf_ld = st_go & (cmd_q == CMD_LD_EEBUF);
  wire act_go = wok & (wofs == OFS_NVM_FIRST_CONTROL_REG) & wd[EXEC_BIT] & prot_ok; // [RULE_18]
  wire crc_go = act_go & (cmd_q == CMD_RANGE_CRC);
  wire fbuf_er = act_go & (cmd_q == CMD_ER_FBUF);
  wire eebuf_er = act_go & (cmd_q == CMD_ER_EEBUF);
  wire chip_go = act_go & (cmd_q == CMD_CHIP_ER) & PDI_REQ;
  wire sup_bad = pot_low_s | (BOD_FORCE & bod_low_s); // [RULE_05]
  wire ee_clr = eebuf_er | ((st_q == ST_EE) & EE_DONE & ~sup_bad &
                (EE_REQ.cmd != CMD_ER_EEPG)); // [RULE_22]
  wire rd_ok = (st_q == ST_IDLE) | ((st_q == ST_PROG) & ~tgt_boot_q & (z_page >= BOOT_PAGE));
  wire ld_go = LOAD_INSTR & rd_ok & (cmd_q == CMD_NOP); // [RULE_18]

  nvmsp_eebuf u_eebuf (
    .clk(CLK), .rst_b(RST_B), .ld(eebuf_ld), .idx(Z_PTR[EE_IW-1:0]), .din(STORE_DATA[7:0]),
    .clr(ee_clr), .tag(ee_tag), .data(ee_data)
  );

  // Sequencer
  always_comb begin
    st_d = st_q;
    tb_d = tgt_boot_q;
    unique case (st_q)
      ST_IDLE: begin
        if (fl_go | chip_go) begin
          st_d = ST_PROG;
          tb_d = chip_go | is_boot | (is_fpg & (z_page >= BOOT_PAGE)); // [RULE_13]
        end else if (crc_go) begin
          st_d = ST_CRC;
        end else if (ee_go) begin
          st_d = ST_EE;
        end
      end
      ST_PROG: if (sup_bad | FL_DONE) st_d = ST_IDLE; // [RULE_05]
      ST_CRC: if (crc_ptr_q == crc_last_q) st_d = ST_IDLE;
      ST_EE: if (sup_bad | EE_DONE) st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q <= ST_IDLE;
      tgt_boot_q <= 1'b0;
      chip_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tgt_boot_q <= tb_d;
      if (st_q == ST_IDLE && (fl_go || chip_go)) chip_q <= chip_go;
    end
  end

  // Halt, read gating and supply detectors follow the next state
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      CPU_HALT <= 1'b0;
      BOOT_RD_EN <= 1'b1;
      APP_RD_EN <= 1'b1;
      POT_DET_EN <= 1'b0;
      BOD_FORCE <= 1'b0;
    end else begin
      CPU_HALT <= (st_d == ST_PROG) | (st_d == ST_CRC); // [RULE_11] [RULE_12]
      BOOT_RD_EN <= ~((st_d == ST_PROG) & tb_d); // [RULE_11] [RULE_12] [RULE_13]
      APP_RD_EN <= st_d != ST_PROG;
      POT_DET_EN <= st_d == ST_PROG; // [RULE_04]
      BOD_FORCE <= PDI_EN | ((st_d == ST_PROG) & (chip_go | chip_q)); // [RULE_04]
    end
  end

  // Flash and EEPROM requests; address latched at start
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      FL_REQ <= '0;
      FL_START <= 1'b0;
      FL_WDATA <= 16'hFFFF;
      FL_ABORT <= 1'b0;
      EE_REQ <= '0;
      EE_START <= 1'b0;
    end else begin
      FL_START <= fl_go | chip_go | fbuf_ld | fbuf_er;
      if (fl_go | fbuf_ld) FL_REQ <= '{cmd: cmd_q, page: z_page, word: z_word}; // [RULE_17]
      else if (chip_go | fbuf_er) FL_REQ <= '{cmd: cmd_q, page: '0, word: '0};
      if (fbuf_ld) FL_WDATA <= STORE_DATA;
      FL_ABORT <= ((st_q == ST_PROG) | (st_q == ST_EE)) & sup_bad; // [RULE_05]
      EE_START <= ee_go;
      if (ee_go) begin
        EE_REQ <= '{cmd: cmd_q, page: Z_PTR[EE_IW+EE_PGW-1:EE_IW], mask: ee_tag,
                    data: ee_data}; // [RULE_21]
      end
    end
  end

  // Byte reads and CRC feed share the read port; CRC holds the CPU so they never meet
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      FL_RADDR <= '0;
      rd_pend_q <= 1'b0;
      rd_sel_q <= 1'b0;
      crc_pend_q <= 1'b0;
      crc_sel_q <= 1'b0;
      crc_ptr_q <= ADDR_RST;
      crc_last_q <= ADDR_RST;
    end else begin
      rd_pend_q <= ld_go;
      crc_pend_q <= st_q == ST_CRC;
      if (ld_go) begin
        FL_RADDR <= Z_PTR[ZW-1:1];
        rd_sel_q <= Z_PTR[0]; // [RULE_16]
      end else if (st_q == ST_CRC) begin
        FL_RADDR <= crc_ptr_q[ZW-1:1];
        crc_sel_q <= crc_ptr_q[0];
        crc_ptr_q <= crc_ptr_q + 1'b1;
      end
      if (crc_go) begin
        crc_ptr_q <= addr_q;
        crc_last_q <= addr_q + ((data_q - addr_q) | ZW'(1)); // [RULE_07]
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      RD_BYTE <= 8'h00;
      RD_VLD <= 1'b0;
      CRC_BYTE <= 8'h00;
      CRC_VLD <= 1'b0;
    end else begin
      RD_VLD <= rd_pend_q;
      if (rd_pend_q) RD_BYTE <= rd_sel_q ? FL_RDATA[15:8] : FL_RDATA[7:0]; // [RULE_16]
      CRC_VLD <= crc_pend_q;
      if (crc_pend_q) CRC_BYTE <= crc_sel_q ? FL_RDATA[15:8] : FL_RDATA[7:0];
    end
  end

  // Registers; status flags: set wins over clear
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cmd_q <= CMD_NOP;
      addr_q <= ADDR_RST;
      data_q <= ADDR_RST;
      abort_q <= 1'b0;
      deny_q <= 1'b0;
    end else begin
      if (wok && wofs == OFS_CMD) cmd_q <= wd[6:0]; // [RULE_20]
      if (wok && wofs == OFS_ADDR) addr_q <= wd[ZW-1:0];
      if (wok && wofs == OFS_DATA) data_q <= wd[ZW-1:0];
      abort_q <= FL_ABORT | (abort_q & ~(wok && wofs == OFS_STATUS && wd[ST_ABORT_BIT]));
      deny_q <= deny | (deny_q & ~(wok && wofs == OFS_STATUS && wd[ST_DENY_BIT]));
    end
  end

  // AXI4-Lite write and read channels
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        S_AXI_AWREADY <= 1'b0;
        aw_have_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        S_AXI_WREADY <= 1'b0;
        w_have_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wok ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rmap ? rd_val : 32'h0;
      S_AXI_RRESP <= rmap ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // Helper: bytes sent in the current CRC run
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) crc_cnt_q <= '0;
    else if (crc_go) crc_cnt_q <= '0;
    else if (CRC_VLD) crc_cnt_q <= crc_cnt_q + 1'b1;
  end

  property p_busy_lock;
    wok |-> !(busy && wofs != OFS_STATUS);
  endproperty
  a_busy_lock: assert property (p_busy_lock) else $error("register written while busy"); // [RULE_20]

  property p_abort;
    (st_q == ST_PROG) && sup_bad |=> (st_q == ST_IDLE) && FL_ABORT ##1 abort_q;
  endproperty
  a_abort: assert property (p_abort) else $error("supply drop did not abort"); // [RULE_05]

  property p_crc_even;
    $fell(CRC_VLD) |-> !crc_cnt_q[0];
  endproperty
  a_crc_even: assert property (p_crc_even) else $error("odd CRC byte count"); // [RULE_07]

  property p_app_noread;
    (st_q == ST_PROG) && !tgt_boot_q && CPU_HALT |-> BOOT_RD_EN && !APP_RD_EN;
  endproperty
  a_app_noread: assert property (p_app_noread) else $error("app op gating wrong"); // [RULE_11]

  property p_boot_noread;
    (st_q == ST_PROG) && tgt_boot_q |-> CPU_HALT && !BOOT_RD_EN && !APP_RD_EN;
  endproperty
  a_boot_noread: assert property (p_boot_noread) else $error("boot op gating wrong"); // [RULE_12]

  property p_latch;
    (st_q == ST_PROG) && $past(st_q == ST_PROG) |-> $stable(FL_REQ);
  endproperty
  a_latch: assert property (p_latch) else $error("address moved during op"); // [RULE_17]

  property p_unlock;
    STORE_INSTR && !busy && is_fw && !PDI_REQ && !CCP_OPEN |=> !FL_START ##1 deny_q;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unprotected trigger ran"); // [RULE_19]

  property p_app_priv;
    STORE_INSTR && !busy && is_fw && !PDI_REQ && !IN_BOOT |=> st_q == ST_IDLE;
  endproperty
  a_app_priv: assert property (p_app_priv) else $error("app code wrote flash"); // [RULE_09]

  property p_byte_sel;
    rd_pend_q |=> RD_VLD && (RD_BYTE == ($past(rd_sel_q) ? $past(FL_RDATA[15:8])
                                                        : $past(FL_RDATA[7:0])));
  endproperty
  a_byte_sel: assert property (p_byte_sel) else $error("wrong read byte"); // [RULE_16]

  property p_bod;
    PDI_EN |=> BOD_FORCE;
  endproperty
  a_bod: assert property (p_bod) else $error("brownout not forced"); // [RULE_04]
endmodule
`default_nettype wire

// ---- common/nvmsp_pkg.sv ----
// Purpose: shared constants and types for the NVM self-programming controller
// Assumes: 32-bit AXI4-Lite register word per register
// Notes: command codes marked local are not fixed elsewhere
package nvmsp_pkg;
  // Pointer split
  localparam int WORD_MSB = 6;
  localparam int PAGE_MSB = 16;
  localparam int ZW = PAGE_MSB + 1;
  localparam int PGW = PAGE_MSB - WORD_MSB;
  localparam int EE_DEPTH = 32;
  localparam int EE_IW = 5;
  localparam int EE_PGW = 6;
  localparam logic [PGW-1:0] BOOT_PAGE_DEF = 10'h3C0;
  // Commands
  localparam logic [6:0] CMD_NOP = 7'h00;
  localparam logic [6:0] CMD_LD_FBUF = 7'h23;
  localparam logic [6:0] CMD_ER_FBUF = 7'h26;
  localparam logic [6:0] CMD_ER_FPG = 7'h2B;
  localparam logic [6:0] CMD_WR_FPG = 7'h2E;
  localparam logic [6:0] CMD_EW_FPG = 7'h2F;
  localparam logic [6:0] CMD_RANGE_CRC = 7'h3A;
  localparam logic [6:0] CMD_ER_APP = 7'h20;
  localparam logic [6:0] CMD_ER_APP_PG = 7'h22;
  localparam logic [6:0] CMD_WR_APP_PG = 7'h24;
  localparam logic [6:0] CMD_EW_APP_PG = 7'h25;
  localparam logic [6:0] CMD_WR_BOOT_PG = 7'h2C;
  localparam logic [6:0] CMD_EW_BOOT_PG = 7'h2D;
  localparam logic [6:0] CMD_ER_USIG = 7'h18;
  localparam logic [6:0] CMD_WR_USIG = 7'h1A;
  // Local codes
  localparam logic [6:0] CMD_LD_EEBUF = 7'h33;
  localparam logic [6:0] CMD_ER_EEBUF = 7'h36;
  localparam logic [6:0] CMD_ER_EEPG = 7'h32;
  localparam logic [6:0] CMD_WR_EEPG = 7'h34;
  localparam logic [6:0] CMD_EW_EEPG = 7'h35;
  localparam logic [6:0] CMD_CHIP_ER = 7'h40;
  // Register map
  localparam logic [4:0] OFS_CMD = 5'h00;
  localparam logic [4:0] OFS_NVM_FIRST_CONTROL_REG = 5'h04;
  localparam logic [4:0] OFS_ADDR = 5'h08;
  localparam logic [4:0] OFS_DATA = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam int EXEC_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ABORT_BIT = 1;
  localparam int ST_DENY_BIT = 2;
  localparam logic [ZW-1:0] ADDR_RST = 17'h00000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_PROG = 4'h2, ST_CRC = 4'h4, ST_EE = 4'h8
  } nvmsp_state_t;
  typedef struct packed {
    logic [6:0] cmd;
    logic [PGW-1:0] page;
    logic [WORD_MSB-1:0] word;
  } nvmsp_freq_t;
  typedef struct packed {
    logic [6:0] cmd;
    logic [EE_PGW-1:0] page;
    logic [EE_DEPTH-1:0] mask;
    logic [8*EE_DEPTH-1:0] data;
  } nvmsp_eereq_t;
endpackage

// ---- hw/nvmsp_sync.sv ----
// Purpose: two-stage synchroniser for pin levels
// Assumes: slow levels only
// Notes: first stage feeds only the second
`timescale 1ns/100ps
`default_nettype none
module nvmsp_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q;
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        s1_q[i] <= 1'b0;
        dout[i] <= 1'b0;
      end else begin
        s1_q[i] <= din[i];
        dout[i] <= s1_q[i];
      end
    end
  end
endmodule
`default_nettype wire

// ---- hw/nvmsp_eebuf.sv ----
// Purpose: EEPROM page buffer with per-byte target marks
// Assumes: one load or clear per cycle
// Notes: loads AND into the old value, as the array does
`timescale 1ns/100ps
`default_nettype none
module nvmsp_eebuf import nvmsp_pkg::*; #(
  parameter int DEPTH = EE_DEPTH,
  parameter int IW = EE_IW
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ld,
  input wire logic [IW-1:0] idx,
  input wire logic [7:0] din,
  input wire logic clr,
  output logic [DEPTH-1:0] tag,
  output logic [8*DEPTH-1:0] data
);
  logic [7:0] mem_q [DEPTH];
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        mem_q[i] <= 8'hFF;
        tag[i] <= 1'b0;
      end else if (clr) begin
        mem_q[i] <= 8'hFF;
        tag[i] <= 1'b0; // [RULE_22]
      end else if (ld && idx == IW'(i)) begin
        mem_q[i] <= mem_q[i] & din;
        tag[i] <= 1'b1; // [RULE_21]
      end
    end
    assign data[i*8 +: 8] = mem_q[i];
  end
endmodule
`default_nettype wire

// ---- dv/nvmsp_array_model.sv ----
// Purpose: flash and EEPROM array stand-in facing the controller
// Assumes: a programming start ends with a done pulse DLY cycles later
// Notes: read data encodes the word address so the byte order shows
`timescale 1ns/100ps
`default_nettype none
module nvmsp_array_model import nvmsp_pkg::*; #(
  parameter int DLY = 12
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Requests
  input wire nvmsp_freq_t FL_REQ,
  input wire logic FL_START,
  input wire logic FL_ABORT,
  input wire logic EE_START,
  input wire logic [15:0] FL_RADDR,
  // Answers
  output logic FL_DONE,
  output logic EE_DONE,
  output logic [15:0] FL_RDATA
);
  int fl_n;
  int ee_n;
  // Buffer loads and erases finish at once, so they get no done
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      fl_n <= 0;
    end else if (FL_ABORT) begin
      fl_n <= 0;
    end else if (FL_START && FL_REQ.cmd != CMD_LD_FBUF && FL_REQ.cmd != CMD_ER_FBUF) begin
      fl_n <= DLY;
    end else if (fl_n > 0) begin
      fl_n <= fl_n - 1;
    end
  end
  // An aborted operation must never see a late done
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ee_n <= 0;
    end else if (FL_ABORT) begin
      ee_n <= 0;
    end else if (EE_START) begin
      ee_n <= DLY;
    end else if (ee_n > 0) begin
      ee_n <= ee_n - 1;
    end
  end
  assign FL_DONE = (fl_n == 1);
  assign EE_DONE = (ee_n == 1);
  assign FL_RDATA = {FL_RADDR[7:0] ^ 8'h5A, FL_RADDR[7:0]};
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Purpose: self-checking bench for the NVM controller
// Assumes: array model answers every programming start
// Notes: stimulus changes only by non-blocking assignment after an edge
`timescale 1ns/100ps
`default_nettype none
module tb_top import nvmsp_pkg::*;;
  logic CLK, RST_B, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR, RD_BYTE, CRC_BYTE;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rdv;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rsp;
  logic IN_BOOT, PDI_REQ, PDI_EN, CCP_OPEN, LOAD_INSTR, STORE_INSTR, RD_VLD, CPU_HALT;
  logic [ZW-1:0] Z_PTR;
  logic [15:0] STORE_DATA, FL_WDATA, FL_RDATA, FL_RADDR;
  logic FL_START, FL_ABORT, FL_DONE, BOOT_RD_EN, APP_RD_EN, EE_START, EE_DONE, CRC_VLD;
  logic POT_LOW, BOD_LOW, POT_DET_EN, BOD_FORCE;
  nvmsp_freq_t FL_REQ;
  nvmsp_eereq_t EE_REQ;
  int num_errors, cmp_count, cyc;
  nvmsp_ctrl i_nvmsp_ctrl (.*);
  nvmsp_array_model i_nvmsp_array_model (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    S_AXI_AWADDR <= {3'h0, a};
    S_AXI_WDATA <= d;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    do begin
      @(posedge CLK);
      n++;
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (!S_AXI_BVALID && n < 50);
    S_AXI_BREADY <= 1'b0;
    rsp = S_AXI_BRESP;
  endtask
  task automatic axr(input logic [4:0] a);
    int n;
    n = 0;
    @(posedge CLK);
    S_AXI_ARADDR <= {3'h0, a};
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    do begin
      @(posedge CLK);
      n++;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!S_AXI_RVALID && n < 50);
    S_AXI_RREADY <= 1'b0;
    rsp = S_AXI_RRESP;
    rdv = S_AXI_RDATA;
  endtask
  task automatic st(input logic [16:0] z, input logic [15:0] d);
    @(posedge CLK);
    Z_PTR <= z;
    STORE_DATA <= d;
    STORE_INSTR <= 1'b1;
    @(posedge CLK);
    STORE_INSTR <= 1'b0;
    #1;
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin
      axr(OFS_STATUS);
      n++;
    end while (rdv[ST_BUSY_BIT] !== 1'b0 && n < 40);
  endtask
  task automatic t_read();
    int n;
    logic [15:0] w;
    w = 16'h91A2;
    for (int b = 0; b < 2; b++) begin
      @(posedge CLK);
      Z_PTR <= {w, b[0]};
      LOAD_INSTR <= 1'b1;
      @(posedge CLK);
      LOAD_INSTR <= 1'b0;
      n = 0;
      do begin
        @(posedge CLK);
        n++;
      end while (!RD_VLD && n < 5);
      chk(FL_RADDR, w);
      chk(RD_BYTE, b ? w[7:0] ^ 8'h5A : w[7:0]);
    end
    $display("t_read done");
  endtask
  task automatic t_sect();
    logic [6:0] c [7] = '{CMD_ER_APP_PG, CMD_WR_APP_PG, CMD_EW_APP_PG, CMD_WR_BOOT_PG,
      CMD_EW_BOOT_PG, CMD_ER_USIG, CMD_WR_USIG};
    logic [16:0] z;
    IN_BOOT <= 1'b1;
    CCP_OPEN <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      z = (i < 3) ? 17'h02A4A : 17'h1E0C6;
      axw(OFS_CMD, {25'h0, c[i]});
      st(z, 16'h0);
      chk(FL_START, 1);
      chk(FL_REQ.cmd, c[i]);
      if (i < 5) chk(FL_REQ, {c[i], z[16:7], z[6:1]});
      chk({CPU_HALT, APP_RD_EN, POT_DET_EN}, 3'b101);
      chk(BOOT_RD_EN, i < 3);
      Z_PTR <= 17'h0;
      axw(OFS_ADDR, 32'h55);
      chk(rsp, RESP_SLVERR);
      if (i < 5) chk(FL_REQ, {c[i], z[16:7], z[6:1]});
      idle();
    end
    axr(OFS_ADDR);
    chk(rdv, 0);
    $display("t_sect done");
  endtask
  task automatic t_deny();
    logic [3:0] cs [3] = '{4'b0010, 4'b1000, 4'b0101};
    for (int i = 0; i < 3; i++) begin
      {IN_BOOT, PDI_REQ, CCP_OPEN} <= cs[i][3:1];
      axw(OFS_CMD, {25'h0, CMD_WR_APP_PG});
      st(17'h02A4A, 16'h0);
      chk(FL_START, cs[i][0]);
      axr(OFS_STATUS);
      chk(rdv[ST_DENY_BIT], !cs[i][0]);
      axw(OFS_STATUS, 32'h4);
      idle();
    end
    axr(5'h14);
    chk({rsp, rdv}, {RESP_SLVERR, 32'h0});
    $display("t_deny done");
  endtask
  task automatic t_ee();
    {IN_BOOT, PDI_REQ, CCP_OPEN} <= 3'b001;
    axw(OFS_CMD, {25'h0, CMD_LD_EEBUF});
    st(17'h00043, 16'h00A5);
    st(17'h0005C, 16'h003C);
    axw(OFS_CMD, {25'h0, CMD_ER_EEPG});
    st(17'h00040, 16'h0);
    chk({EE_START, EE_REQ.page, EE_REQ.mask}, {1'b1, 6'h2, 32'h10000008});
    idle();
    axw(OFS_CMD, {25'h0, CMD_WR_EEPG});
    st(17'h00040, 16'h0);
    chk(EE_REQ.mask, 32'h10000008);
    chk(EE_REQ.data[31:0], 32'hA5FFFFFF);
    idle();
    axw(OFS_CMD, {25'h0, CMD_LD_EEBUF});
    st(17'h00045, 16'h0011);
    axw(OFS_CMD, {25'h0, CMD_ER_EEBUF});
    axw(OFS_NVM_FIRST_CONTROL_REG, 32'h1);
    idle();
    axw(OFS_CMD, {25'h0, CMD_LD_EEBUF});
    st(17'h00049, 16'h0022);
    axw(OFS_CMD, {25'h0, CMD_EW_EEPG});
    st(17'h00040, 16'h0);
    chk(EE_REQ.mask, 32'h00000200);
    idle();
    $display("t_ee done");
  endtask
  task automatic t_abort();
    int n;
    {IN_BOOT, CCP_OPEN, PDI_EN} <= 3'b111;
    axw(OFS_CMD, {25'h0, CMD_WR_APP_PG});
    st(17'h02A4A, 16'h0);
    POT_LOW <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (!FL_ABORT && n < 8);
    chk(FL_ABORT, 1);
    chk(BOD_FORCE, 1);
    axr(OFS_STATUS);
    chk(rdv[1:0], 2'b10);
    POT_LOW <= 1'b0;
    axw(OFS_STATUS, 32'h2);
    repeat (4) @(posedge CLK);
    st(17'h02A4A, 16'h0);
    chk(FL_START, 1);
    idle();
    chk(rdv[1:0], 2'b00);
    PDI_EN <= 1'b0;
    $display("t_abort done");
  endtask
  task automatic t_crc();
    int n;
    int c;
    logic [7:0] tl [2] = '{8'h14, 8'h13};
    for (int i = 0; i < 2; i++) begin
      axw(OFS_CMD, {25'h0, CMD_RANGE_CRC});
      axw(OFS_ADDR, 32'h10);
      axw(OFS_DATA, {24'h0, tl[i]});
      axw(OFS_NVM_FIRST_CONTROL_REG, 32'h1);
      n = 0;
      c = 0;
      do begin
        @(posedge CLK);
        n++;
        if (CRC_VLD === 1'b1) c++;
      end while ((n < 4 || CPU_HALT || CRC_VLD) && n < 80);
      chk(c, i ? 4 : 6);
      chk(CRC_BYTE, i ? 8'h53 : 8'h50);
    end
    $display("t_crc done");
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // Whole run needs a few hundred cycles; the ceiling at 20000 leaves wide room
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    {num_errors, cmp_count, cyc, RST_B, S_AXI_WSTRB} = {96'h0, 1'b0, 4'hF};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {IN_BOOT, PDI_REQ, PDI_EN, CCP_OPEN, LOAD_INSTR, STORE_INSTR, POT_LOW, BOD_LOW} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, Z_PTR, STORE_DATA} = '0;
    repeat (20) @(posedge CLK);
    RST_B <= 1'b1;
    t_read();
    t_sect();
    t_deny();
    t_ee();
    t_abort();
    t_crc();
    stop_test();
  end
endmodule
`default_nettype wire
